// ==== logic/gp_page_pin_function_mux.sv ====
// General-purpose page registers 13G/14G and the multi-function pin mux
`timescale 1ns/1ps
`default_nettype none

module gp_page_pin_function_mux
    import gp_page_pkg::*;
#(
    parameter int N_LED = 4
) (
    input  wire logic                 clk_sys,          // Management clock
    input  wire logic                 rst,              // Power-on reset, loads the reset value of every register
    input  wire logic                 ce,               // Clock enable
    input  wire logic                 soft_rst,         // Device soft reset
    input  wire logic                 reg_wr,           // Register write strobe
    input  wire logic                 reg_rd,           // Register read strobe
    input  wire logic [REG_AW-1:0]    reg_addr,         // Register address 0..31
    input  wire logic [REG_DW-1:0]    reg_wdata,        // Write data
    output logic      [REG_DW-1:0]    reg_rdata,        // Read data
    output logic                      reg_rvalid,       // Read data valid
    output logic                      reg_claimed,      // This block answered the access
    output logic      [REG_DW-1:0]    page_code,        // Current page code
    output logic                      gp_page_active,   // General-purpose page selected
    input  wire pin_drive_s           ded_drive,        // Dedicated function drives
    input  wire pin_drive_s           gpio_drive,       // GPIO output and enable registers
    output logic      [N_PINS-1:0]    gpio_in_val,      // Sampled pin levels for GPIO input
    output logic      [N_PINS-1:0]    ded_in_val,       // Pin levels to dedicated inputs
    output logic      [N_FIBRE_SIGNAL_DETECT-1:0]  fibre_signal_detect, // Per-port signal detect
    input  wire logic [N_PINS-1:0]    mf_pin_i,         // Multi-function pin input
    output logic      [N_PINS-1:0]    mf_pin_o,         // Multi-function pin output
    output logic      [N_PINS-1:0]    mf_pin_oe,        // Multi-function pin enable
    input  wire logic                 low_power_hold_pin_i,  // Hold pin input
    output logic                      low_power_hold_pin_o,  // Hold pin output
    output logic                      low_power_hold_pin_oe, // Hold pin enable
    output logic                      low_power_hold_level,  // Filtered hold pin level
    output logic                      pps_1_3_oe,       // Pulse outputs 1 to 3 enable
    input  wire logic [N_LED-1:0]     led_status,       // Per-PHY LED status
    input  wire logic [N_LED-1:0]     led_use_gpio,     // LED pin used as GPIO
    input  wire logic [N_LED-1:0]     led_gpio_out,     // LED pin GPIO output value
    input  wire logic [N_LED-1:0]     led_gpio_oe,      // LED pin GPIO output enable
    output logic      [N_LED-1:0]     led_pin_o,        // LED pin output
    output logic      [N_LED-1:0]     led_pin_oe,       // LED pin enable
    output logic      [N_LED-1:0]     led_gpio_in       // Driven LED pin level for GPIO input
);

    // =========================================================================
    // Helpers
    function automatic logic gp_reg_hit(input logic [4:0] a, input logic [4:0] target);
        gp_reg_hit = (a == target);
    endfunction

    function automatic logic od_enable(input logic o, input logic oe, input logic flt);
        od_enable = oe & ~(flt & o);
    endfunction

    function automatic pin_fn_e pin_code(input logic [REG_DW-1:0] r, input int lsb);
        pin_code = pin_fn_e'(r[lsb +: 2]);
    endfunction

    function automatic logic is_tws_pin(input int idx);
        is_tws_pin = (idx >= PIN_SCL0) && (idx <= PIN_SDA);
    endfunction

    // =========================================================================
    // Page register
    logic [REG_DW-1:0] page_reg;
    logic              gp_sel;

    assign gp_sel         = (page_reg == PAGE_GP);
    assign page_code      = page_reg;
    assign gp_page_active = gp_sel;

    always_ff @(posedge clk_sys) begin
        if (rst || (ce && soft_rst)) begin
            page_reg <= PAGE_MAIN;
        end else if (ce && reg_wr && gp_reg_hit(reg_addr, PAGE_REG_ADDR)) begin
            page_reg <= reg_wdata;
        end
    end

    // =========================================================================
    // Super-sticky configuration registers, set to their reset values by power-on reset only
    logic [REG_DW-1:0] led_fibre_signal_detect_pin_function_select_reg;
    logic [REG_DW-1:0] aux_pin_function_control_reg;
    logic              wr_pin_sel;
    logic              wr_aux;

    assign wr_pin_sel = ce && reg_wr && gp_sel && gp_reg_hit(reg_addr, GP_PIN_SEL_ADDR);
    assign wr_aux     = ce && reg_wr && gp_sel && gp_reg_hit(reg_addr, GP_AUX_CTL_ADDR);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_fibre_signal_detect_pin_function_select_reg <= PIN_SEL_RESET;
        end else if (wr_pin_sel) begin
            led_fibre_signal_detect_pin_function_select_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aux_pin_function_control_reg <= AUX_CTL_RESET;
        end else if (wr_aux) begin
            aux_pin_function_control_reg <= reg_wdata & AUX_CTL_WMASK;
        end
    end

    // =========================================================================
    // Pin input synchronisers: three stages, accepted when stages two and three agree
    logic [N_PINS:0] sync1_reg;
    logic [N_PINS:0] sync2_reg;
    logic [N_PINS:0] sync3_reg;
    logic [N_PINS:0] filt_reg;
    logic [N_LED-1:0] led_s1_reg;
    logic [N_LED-1:0] led_s2_reg;
    logic [N_LED-1:0] led_s3_reg;
    logic [N_LED-1:0] led_filt_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else if (ce) begin
            sync1_reg <= {low_power_hold_pin_i, mf_pin_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // LED readback is the driven level, filtered like the other pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_s1_reg <= '0;
            led_s2_reg <= '0;
            led_s3_reg <= '0;
        end else if (ce) begin
            led_s1_reg <= led_pin_o;
            led_s2_reg <= led_s1_reg;
            led_s3_reg <= led_s2_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            filt_reg <= '0;
        end else if (ce) begin
            for (int i = 0; i <= N_PINS; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    filt_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_filt_reg <= '0;
        end else if (ce) begin
            for (int j = 0; j < N_LED; j++) begin
                if (led_s2_reg[j] == led_s3_reg[j]) begin
                    led_filt_reg[j] <= led_s3_reg[j];
                end
            end
        end
    end

    assign gpio_in_val          = filt_reg[N_PINS-1:0];
    assign low_power_hold_level = filt_reg[N_PINS];
    assign led_gpio_in          = led_filt_reg;

    // =========================================================================
    // Per-pin function codes
    pin_fn_e pin_fn [N_PINS];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_fn[i] = pin_code(led_fibre_signal_detect_pin_function_select_reg, 2*i);
        end
        pin_fn[PIN_SDA]    = pin_code(aux_pin_function_control_reg, AUX_SDA_LSB);
        pin_fn[PIN_QLL]    = pin_code(aux_pin_function_control_reg, AUX_QLL_LSB);
        pin_fn[PIN_LDSV]   = pin_code(aux_pin_function_control_reg, AUX_LDSV_LSB);
        pin_fn[PIN_PPS0]   = pin_code(aux_pin_function_control_reg, AUX_PPS0_LSB);
        pin_fn[PIN_SPI_CS] = pin_code(aux_pin_function_control_reg, AUX_SPI_LSB);
        pin_fn[PIN_SPI_DO] = pin_code(aux_pin_function_control_reg, AUX_SPI_LSB);
    end

    // =========================================================================
    // Pin mux; reserved codes leave the pin floating and its dedicated input low
    logic [N_PINS-1:0] pin_o_next;
    logic [N_PINS-1:0] pin_oe_next;
    logic [N_PINS-1:0] ded_in_next;
    logic              tws_float;

    assign tws_float = aux_pin_function_control_reg[AUX_TWS_FLOAT];

    always_comb begin
        pin_o_next  = '0;
        pin_oe_next = '0;
        ded_in_next = '0;
        for (int i = 0; i < N_PINS; i++) begin
            case (pin_fn[i])
                FN_DEDICATED: begin
                    pin_o_next[i]  = ded_drive.val[i];
                    pin_oe_next[i] = ded_drive.en[i];
                    ded_in_next[i] = filt_reg[i];
                    if (is_tws_pin(i)) begin
                        pin_oe_next[i] = od_enable(ded_drive.val[i], ded_drive.en[i],
                                                   tws_float);
                    end
                end
                FN_GPIO: begin
                    pin_o_next[i]  = gpio_drive.val[i];
                    pin_oe_next[i] = gpio_drive.en[i];
                end
                default: begin
                    pin_o_next[i]  = 1'b0;
                    pin_oe_next[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mf_pin_o   <= '0;
            mf_pin_oe  <= '0;
            ded_in_val <= '0;
        end else if (ce) begin
            mf_pin_o   <= pin_o_next;
            mf_pin_oe  <= pin_oe_next;
            ded_in_val <= ded_in_next;
        end
    end

    assign fibre_signal_detect = ded_in_val[PIN_SIGDET0 +: N_FIBRE_SIGNAL_DETECT];

    // =========================================================================
    // LED pins
    logic [N_LED-1:0] led_o_next;
    logic [N_LED-1:0] led_oe_next;

    always_comb begin
        led_o_next  = '0;
        led_oe_next = '0;
        for (int j = 0; j < N_LED; j++) begin
            if (led_use_gpio[j]) begin
                led_o_next[j]  = led_gpio_out[j];
                led_oe_next[j] = led_gpio_oe[j];
            end else begin
                led_o_next[j]  = led_status[j];
                led_oe_next[j] = 1'b1;
            end
            led_oe_next[j] = od_enable(led_o_next[j], led_oe_next[j],
                                       aux_pin_function_control_reg[AUX_LED_FLOAT]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_pin_o  <= '0;
            led_pin_oe <= '0;
        end else if (ce) begin
            led_pin_o  <= led_o_next;
            led_pin_oe <= led_oe_next;
        end
    end

    // =========================================================================
    // Low-power hold pin and pulse output gate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            low_power_hold_pin_o  <= 1'b0;
            low_power_hold_pin_oe <= 1'b0;
            pps_1_3_oe            <= 1'b0;
        end else if (ce) begin
            low_power_hold_pin_oe <= ~aux_pin_function_control_reg[AUX_LOWPWR_OEN];
            low_power_hold_pin_o  <= aux_pin_function_control_reg[AUX_LOWPWR_OUT];
            pps_1_3_oe            <= aux_pin_function_control_reg[AUX_PPS13_OE];
        end
    end

    // =========================================================================
    // Read path: one cycle after the strobe
    logic [REG_DW-1:0] rdata_next;
    logic              claim_next;

    always_comb begin
        rdata_next = '0;
        claim_next = 1'b1;
        if (gp_reg_hit(reg_addr, PAGE_REG_ADDR)) begin
            rdata_next = page_reg;
        end else if (!gp_sel) begin
            claim_next = 1'b0;
        end else if (gp_reg_hit(reg_addr, GP_PIN_SEL_ADDR)) begin
            rdata_next = led_fibre_signal_detect_pin_function_select_reg;
        end else if (gp_reg_hit(reg_addr, GP_AUX_CTL_ADDR)) begin
            rdata_next = aux_pin_function_control_reg;
            rdata_next[AUX_LOWPWR_IN] = low_power_hold_level;
        end else if (reg_addr <= GP_RSVD_LAST || gp_reg_hit(reg_addr, GP_RSVD_30)) begin
            rdata_next = '0;
        end else begin
            claim_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
        end
    end

    // Data and claim hold until the next read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata   <= '0;
            reg_claimed <= 1'b0;
        end else if (ce && reg_rd) begin
            reg_rdata   <= rdata_next;
            reg_claimed <= claim_next;
        end
    end

endmodule

`default_nettype wire

// ==== logic/gp_page_pkg.sv ====
// Constants and types for the general-purpose page pin-function block
package gp_page_pkg;

    // =========================================================================
    // Management map
    localparam int          REG_AW          = 5;
    localparam int          REG_DW          = 16;
    localparam logic [4:0]  PAGE_REG_ADDR   = 5'h1F;
    localparam logic [15:0] PAGE_MAIN       = 16'h0000;
    localparam logic [15:0] PAGE_GP         = 16'h0010;
    localparam logic [4:0]  GP_RSVD_LAST    = 5'h0C;
    localparam logic [4:0]  GP_PIN_SEL_ADDR = 5'h0D;
    localparam logic [4:0]  GP_AUX_CTL_ADDR = 5'h0E;
    localparam logic [4:0]  GP_RSVD_30      = 5'h1E;

    // =========================================================================
    // Reset values and write masks
    localparam logic [15:0] PIN_SEL_RESET   = 16'h0000;
    localparam logic [15:0] AUX_CTL_RESET   = 16'h2600;
    localparam logic [15:0] AUX_CTL_WMASK   = 16'hF7FF;

    // =========================================================================
    // Field positions in aux_pin_function_control
    localparam int AUX_SPI_LSB     = 14;
    localparam int AUX_LOWPWR_OEN  = 13;
    localparam int AUX_LOWPWR_OUT  = 12;
    localparam int AUX_LOWPWR_IN   = 11;
    localparam int AUX_TWS_FLOAT   = 10;
    localparam int AUX_LED_FLOAT   = 9;
    localparam int AUX_PPS13_OE    = 8;
    localparam int AUX_PPS0_LSB    = 6;
    localparam int AUX_LDSV_LSB    = 4;
    localparam int AUX_QLL_LSB     = 2;
    localparam int AUX_SDA_LSB     = 0;

    // =========================================================================
    // Multi-function pin indices
    localparam int N_PINS      = 14;
    localparam int PIN_SIGDET0 = 0;
    localparam int PIN_SCL0    = 4;
    localparam int PIN_SDA     = 8;
    localparam int PIN_QLL     = 9;
    localparam int PIN_LDSV    = 10;
    localparam int PIN_PPS0    = 11;
    localparam int PIN_SPI_CS  = 12;
    localparam int PIN_SPI_DO  = 13;
    localparam int N_FIBRE_SIGNAL_DETECT    = 4;
    localparam int N_SCL       = 4;

    // =========================================================================
    // Pin-function codes
    typedef enum logic [1:0] {
        FN_DEDICATED = 2'b00,
        FN_RSVD_01   = 2'b01,
        FN_RSVD_10   = 2'b10,
        FN_GPIO      = 2'b11
    } pin_fn_e;

    // Output value and output enable for a group of pins
    typedef struct packed {
        logic [N_PINS-1:0] val;
        logic [N_PINS-1:0] en;
    } pin_drive_s;

endpackage

// ==== tb/gp_page_pin_function_mux_chk.sv ====
// Port-level assertions for the general-purpose page pin-function block
`timescale 1ns/1ps
`default_nettype none

module gp_page_pin_function_mux_chk
    import gp_page_pkg::*;
#(
    parameter int N_LED = 4
) (
    input wire logic              clk_sys,             // Clock
    input wire logic              rst,                 // Reset
    input wire logic              ce,                  // Clock enable
    input wire logic              soft_rst,            // Soft reset
    input wire logic              reg_wr,              // Write strobe
    input wire logic              reg_rd,              // Read strobe
    input wire logic [REG_AW-1:0] reg_addr,            // Address
    input wire logic [REG_DW-1:0] reg_wdata,           // Write data
    input wire logic [REG_DW-1:0] reg_rdata,           // Read data
    input wire logic              reg_rvalid,          // Read valid
    input wire logic              reg_claimed,         // Claimed
    input wire logic [REG_DW-1:0] page_code,           // Page code
    input wire logic              gp_page_active,      // Page selected
    input wire pin_drive_s        ded_drive,           // Dedicated drives
    input wire pin_drive_s        gpio_drive,          // GPIO drives
    input wire logic [N_PINS-1:0] ded_in_val,          // Dedicated inputs
    input wire logic [N_FIBRE_SIGNAL_DETECT-1:0] fibre_signal_detect, // Signal detect
    input wire logic [N_PINS-1:0] mf_pin_oe,           // Pin enables
    input wire logic              low_power_hold_pin_o,  // Hold pin out
    input wire logic              low_power_hold_pin_oe, // Hold pin enable
    input wire logic              pps_1_3_oe,          // Pulse enable
    input wire logic [N_LED-1:0]  led_pin_o,           // LED out
    input wire logic [N_LED-1:0]  led_pin_oe           // LED enable
);
    logic                aux_wr;
    logic                led_flt_q;
    logic                sel_wr;
    logic [REG_DW-1:0]   sel_q;
    logic [N_FIBRE_SIGNAL_DETECT-1:0] sd_ded;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    assign aux_wr = ce && reg_wr && gp_page_active && reg_addr == GP_AUX_CTL_ADDR;
    assign sel_wr = ce && reg_wr && gp_page_active && reg_addr == GP_PIN_SEL_ADDR;

    // Shadow of the LED float bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            led_flt_q <= AUX_CTL_RESET[AUX_LED_FLOAT];
        end else if (aux_wr) begin
            led_flt_q <= reg_wdata[AUX_LED_FLOAT];
        end
    end

    // Shadow of the pin-select register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_q <= PIN_SEL_RESET;
        end else if (sel_wr) begin
            sel_q <= reg_wdata;
        end
    end

    always_comb begin
        for (int i = 0; i < N_FIBRE_SIGNAL_DETECT; i++) begin
            sd_ded[i] = (sel_q[2*i +: 2] == 2'b00);
        end
    end

    page_gp_enter_a: assert property (ce && reg_wr && reg_addr == PAGE_REG_ADDR
        && reg_wdata == PAGE_GP |=> gp_page_active) else $error("page code not taken");
    page_main_return_a: assert property (ce && reg_wr && reg_addr == PAGE_REG_ADDR
        && reg_wdata == PAGE_MAIN |=> !gp_page_active && page_code == 16'h0000)
        else $error("main page not restored");
    reserved_read_zero_a: assert property (ce && reg_rd && gp_page_active
        && (reg_addr <= GP_RSVD_LAST || reg_addr == GP_RSVD_30)
        |=> reg_rvalid && reg_claimed && reg_rdata == 16'h0000) else $error("reserved read");
    sticky_soft_rst_a: assert property ((soft_rst && !reg_wr)[*3] |-> $stable(pps_1_3_oe))
        else $error("soft reset changed page bits");
    hold_oe_follow_a: assert property (aux_wr |=> ##1
        low_power_hold_pin_oe == !$past(reg_wdata[AUX_LOWPWR_OEN], 2)) else $error("hold oe");
    hold_out_value_a: assert property (aux_wr && !reg_wdata[AUX_LOWPWR_OEN] |=> ##1
        low_power_hold_pin_o == $past(reg_wdata[AUX_LOWPWR_OUT], 2)) else $error("hold out");
    fibre_signal_detect_gate_a: assert property (sel_q == $past(sel_q) && $past(ce)
        |-> (fibre_signal_detect & ~sd_ded) == '0) else $error("signal detect not gated");
    pin_enable_gate_a: assert property ((mf_pin_oe & ~($past(ded_drive.en)
        | $past(gpio_drive.en))) == '0) else $error("pin driven without enable");
    led_float_high_a: assert property (led_flt_q && $past(led_flt_q) && $past(ce)
        |-> (led_pin_oe & led_pin_o) == '0) else $error("LED driven high");

    cover property (gp_page_active && reg_rd && reg_addr == GP_PIN_SEL_ADDR);
    cover property (low_power_hold_pin_oe && low_power_hold_pin_o);
    cover property (soft_rst && gp_page_active);
endmodule

`default_nettype wire

// ==== tb/gp_page_pin_function_mux_test.sv ====
// Self-checking testbench for the general-purpose page pin-function block
`timescale 1ns/1ps
`default_nettype none

module gp_page_pin_function_mux_test;
    import gp_page_pkg::*;

    logic clk_sys = 0, rst = 1, ce = 1, soft_rst = 0, reg_wr = 0, reg_rd = 0;
    logic [4:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0;
    pin_drive_s ded_drive = '{val: 14'h2A5A, en: 14'h3FFF};
    pin_drive_s gpio_drive = '{val: 14'h155A, en: 14'h0F0F};
    logic [13:0] pin_ext = 14'h1B6D;
    logic [3:0] led_status = 4'hA, led_use_gpio = 4'h3, led_gpio_out = 4'h5, led_gpio_oe = 4'h6;
    wire logic [15:0] reg_rdata;
    wire logic reg_rvalid, reg_claimed, hold_o, hold_oe;
    wire logic [13:0] gpio_in_val, ded_in_val, mf_pin_o, mf_pin_oe, pin_lvl;
    wire logic [3:0] fibre_signal_detect, led_pin_o, led_pin_oe, led_gpio_in;
    wire logic pps_1_3_oe, hold_lvl, hold_seen;
    int errors = 0, checks = 0;
    logic [15:0] cfg [4] = '{16'h0000, 16'hFFFF, 16'h1B4E, 16'h00C3};
    logic [15:0] acfg [4] = '{16'h2600, 16'hC0FF, 16'h5934, 16'hA7C3};

    // Wire levels seen by the block where it may drive the pins itself
    assign pin_lvl = (mf_pin_oe & mf_pin_o) | (~mf_pin_oe & pin_ext);
    assign hold_lvl = hold_oe ? hold_o : 1'b1;

    always #2.5 clk_sys = ~clk_sys;

    gp_page_pin_function_mux #(.N_LED(4)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .soft_rst(soft_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_claimed(reg_claimed), .page_code(),
        .gp_page_active(), .ded_drive(ded_drive), .gpio_drive(gpio_drive),
        .gpio_in_val(gpio_in_val), .ded_in_val(ded_in_val),
        .fibre_signal_detect(fibre_signal_detect), .mf_pin_i(pin_lvl), .mf_pin_o(mf_pin_o),
        .mf_pin_oe(mf_pin_oe), .low_power_hold_pin_i(hold_lvl), .low_power_hold_pin_o(hold_o),
        .low_power_hold_pin_oe(hold_oe), .low_power_hold_level(hold_seen),
        .pps_1_3_oe(pps_1_3_oe),
        .led_status(led_status), .led_use_gpio(led_use_gpio), .led_gpio_out(led_gpio_out),
        .led_gpio_oe(led_gpio_oe), .led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe),
        .led_gpio_in(led_gpio_in));

    task automatic wrap_up();
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input logic claim);
        int n;
        @(negedge clk_sys);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk_sys);
        if (n == 4) begin
            errors++;
            wrap_up();
        end else begin
            chk("rdata", exp, reg_rdata);
            chk("claimed", claim, reg_claimed);
        end
    endtask

    task automatic pins(input logic [15:0] sel, input logic [15:0] aux);
        logic [1:0] f;
        logic [13:0] eoe, eo, dm;
        logic [3:0] lv, loe;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < 14; i++) begin
            f = i < 4 ? sel[2*i+:2] : i < 8 ? sel[8+2*(i-4)+:2] :
                i < 12 ? aux[2*(i-8)+:2] : aux[15:14];
            dm[i] = f == FN_DEDICATED;
            eo[i] = f == FN_GPIO ? gpio_drive.val[i] : ded_drive.val[i];
            eoe[i] = f == FN_GPIO ? gpio_drive.en[i] : dm[i] && ded_drive.en[i]
                && !(i >= 4 && i <= 8 && aux[10] && ded_drive.val[i]);
        end
        for (int i = 0; i < 4; i++) begin
            lv[i] = led_use_gpio[i] ? led_gpio_out[i] : led_status[i];
            loe[i] = (led_use_gpio[i] ? led_gpio_oe[i] : 1'b1) && !(aux[9] && lv[i]);
        end
        chk("pin_oe", eoe, mf_pin_oe);
        chk("pin_out", eo & eoe, mf_pin_o & eoe);
        chk("gpio_in", pin_lvl, gpio_in_val);
        chk("ded_in", pin_lvl & dm, ded_in_val);
        chk("fibre_signal_detect", pin_lvl[3:0] & dm[3:0], fibre_signal_detect);
        chk("hold_oe", !aux[13], hold_oe);
        if (!aux[13]) chk("hold_out", aux[12], hold_o);
        chk("pps13_oe", aux[8], pps_1_3_oe);
        chk("led_oe", loe, led_pin_oe);
        chk("led_out", lv & loe, led_pin_o & loe);
        chk("led_in", led_pin_o, led_gpio_in);
        chk("hold_lvl", hold_lvl, hold_seen);
        rd(GP_PIN_SEL_ADDR, sel, 1);
        rd(GP_AUX_CTL_ADDR, (aux & AUX_CTL_WMASK) | {4'h0, aux[13] | aux[12], 11'h0}, 1);
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        rst = 0;
        rd(PAGE_REG_ADDR, PAGE_MAIN, 1);
        rd(GP_PIN_SEL_ADDR, 16'h0000, 0);
        wr(GP_PIN_SEL_ADDR, 16'hFFFF);
        wr(PAGE_REG_ADDR, PAGE_GP);
        rd(PAGE_REG_ADDR, PAGE_GP, 1);
        pins(PIN_SEL_RESET, AUX_CTL_RESET);
        foreach (cfg[k]) begin
            wr(5'h0C, cfg[k]);
            rd(5'h0C, 16'h0000, 1);
        end
        rd(5'h00, 16'h0000, 1);
        rd(GP_RSVD_30, 16'h0000, 1);
        for (int k = 1; k < 4; k++) begin
            wr(GP_PIN_SEL_ADDR, cfg[k]);
            wr(GP_AUX_CTL_ADDR, acfg[k]);
            pins(cfg[k], acfg[k]);
        end
        ce = 0;
        wr(GP_PIN_SEL_ADDR, 16'h0000);
        ce = 1;
        rd(GP_PIN_SEL_ADDR, cfg[3], 1);
        soft_rst = 1;
        repeat (4) @(negedge clk_sys);
        soft_rst = 0;
        wr(PAGE_REG_ADDR, PAGE_GP);
        pins(cfg[3], acfg[3]);
        wr(PAGE_REG_ADDR, PAGE_MAIN);
        rd(GP_AUX_CTL_ADDR, 16'h0000, 0);
        wrap_up();
    end
endmodule

bind gp_page_pin_function_mux gp_page_pin_function_mux_chk #(.N_LED(N_LED)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .soft_rst(soft_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_claimed(reg_claimed), .page_code(page_code),
    .gp_page_active(gp_page_active), .ded_drive(ded_drive), .gpio_drive(gpio_drive),
    .ded_in_val(ded_in_val), .fibre_signal_detect(fibre_signal_detect),
    .mf_pin_oe(mf_pin_oe), .low_power_hold_pin_o(low_power_hold_pin_o),
    .low_power_hold_pin_oe(low_power_hold_pin_oe), .pps_1_3_oe(pps_1_3_oe),
    .led_pin_o(led_pin_o), .led_pin_oe(led_pin_oe));

`default_nettype wire
